/* common/upc_cfg.svh */
`ifndef UPC_CFG_SVH
`define UPC_CFG_SVH

// register byte offsets on the bus, one aligned word each
`define UPC_OFF_PINS      8'h00
`define UPC_OFF_LATCH     8'h04
`define UPC_OFF_DIR       8'h08
`define UPC_OFF_INTC      8'h0c
`define UPC_OFF_INTC2     8'h10
`define UPC_OFF_INTC3     8'h14
`define UPC_OFF_ANSEL     8'h18
`define UPC_OFF_IRQ_STAT  8'h1c
`define UPC_OFF_IRQ_MASK  8'h20

// field positions inside the 8-bit registers
`define UPC_INTC_FLAG_BIT  0
`define UPC_INTC_IE_BIT    3
`define UPC_INTC2_PUD_BIT  7
`define UPC_INTC2_PRIO_BIT 0
`define UPC_ANSEL_AN_BIT   4

// pin index inside the upper nibble (0 = bit 4 of the port)
`define UPC_AN_PIN     0
`define UPC_HADDR1_PIN 0
`define UPC_HADDR0_PIN 1
`define UPC_DBG_CLK_PIN 2
`define UPC_DBG_DAT_PIN 3

// debug roles of a pin cell
`define UPC_DBG_NONE 2'h0
`define UPC_DBG_CLK  2'h1
`define UPC_DBG_DAT  2'h2

// reset values
`define UPC_RST_LATCH 4'h0
`define UPC_RST_DIR   4'hf
`define UPC_RST_INTC  8'h00
`define UPC_RST_INTC2 8'h80
`define UPC_RST_INTC3 8'h00

`endif

/* common/upc_pkg.sv */
package upc_pkg;
   // one 8-bit register image
   typedef logic [7:0] upc_reg_t;
   // one bit per upper pin
   typedef logic [3:0] upc_nib_t;
   // which source drives a pin's output buffer
   typedef enum logic [1:0] {
      src_latch,
      src_remap,
      src_haddr,
      src_debug
   } upc_src_t;
endpackage

/* src/upc_pin_cell.sv */
`include "upc_cfg.svh"

module upc_pin_cell #(
   parameter bit         HAS_ANALOG = 1'b0,
   parameter bit         HAS_HADDR  = 1'b0,
   parameter logic [1:0] DBG_ROLE   = 2'h0
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // software controls
   input  wire logic latch_i,
   input  wire logic dir_i,
   input  wire logic pud_n_i,
   input  wire logic analog_i,
   // alternate sources
   input  wire logic remap_sel_i,
   input  wire logic remap_out_i,
   input  wire logic haddr_en_i,
   input  wire logic haddr_i,
   input  wire logic dbg_en_i,
   input  wire logic dbg_oe_i,
   input  wire logic dbg_out_i,
   // pad
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe_o,
   output logic      pullup_o,
   output logic      din_o
);
   upc_pkg::upc_src_t src;       // chosen output source
   logic              dbg_own;   // debug owns this pin
   logic              an_on;     // analog function active
   logic              nxt_out;   // next pad value
   logic              nxt_oe;    // next pad enable

   assign dbg_own = (DBG_ROLE != `UPC_DBG_NONE) && dbg_en_i;
   assign an_on   = HAS_ANALOG && analog_i;

   // source priority: debug, host address, remap, latch
   always_comb begin
      if (dbg_own) begin
         src = upc_pkg::src_debug;
      end else if (HAS_HADDR && haddr_en_i && !dir_i) begin
         src = upc_pkg::src_haddr;
      end else if (remap_sel_i && !dir_i) begin
         src = upc_pkg::src_remap;
      end else begin
         src = upc_pkg::src_latch;
      end
   end

   // output value; analog selection deliberately not in this path
   always_comb begin
      case (src)
         upc_pkg::src_debug: nxt_out = dbg_out_i;
         upc_pkg::src_haddr: nxt_out = haddr_i;
         upc_pkg::src_remap: nxt_out = remap_out_i;
         default:            nxt_out = latch_i;
      endcase
   end

   // under debug the clock pin is never driven and the data pin follows the debugger; otherwise direction decides
   always_comb begin
      if (dbg_own) begin
         nxt_oe = (DBG_ROLE == `UPC_DBG_DAT) && dbg_oe_i;
      end else begin
         nxt_oe = !dir_i;
      end
   end

   // pad registers, so every pad signal leaves a flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o    <= 1'b0;
         pin_oe_o <= 1'b0;
         pullup_o <= 1'b0;
         din_o    <= 1'b0;
      end else begin
         pin_o    <= nxt_out;
         pin_oe_o <= nxt_oe;
         // pull-up only for a digital input with the global enable low
         pullup_o <= dir_i && !pud_n_i && !an_on && !dbg_own;
         // analog or debug use hides the level from digital readers
         din_o    <= (an_on || dbg_own) ? 1'b0 : pin_i;
      end
   end

   pullup_output_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !dir_i |=> !pullup_o) else $error("pull-up on while output");
   analog_hides_a: assert property (@(posedge clk_i) disable iff (rst_i)
      an_on |=> !din_o && !pullup_o) else $error("analog pin not isolated");
endmodule

/* src/upc_change_det.sv */
module upc_change_det (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // current levels and direction
   input  wire upc_pkg::upc_nib_t din_i,
   input  wire upc_pkg::upc_nib_t dir_i,
   // port access that refreshes the old copy
   input  wire logic             snap_i,
   // any input differs from the old copy
   output logic                  mismatch_o
);
   upc_pkg::upc_nib_t old_ff; // levels seen at the last port access

   // old copy taken on each port access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         old_ff <= 4'h0;
      end else if (snap_i) begin
         old_ff <= din_i;
      end
   end

   // only inputs take part; outputs are masked out
   assign mismatch_o = |((din_i ^ old_ff) & dir_i);

   // levels unchanged since the access: the fresh copy must match them
   snap_ends_a: assert property (@(posedge clk_i) disable iff (rst_i)
      snap_i ##1 $stable(din_i) |-> !mismatch_o)
      else $error("mismatch kept after port access");
   output_excluded_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dir_i == 4'h0 |-> !mismatch_o) else $error("output pin raised change");
endmodule

/* src/upc_port_top.sv */
// What this block does
// - output pins drive latch, analog ignored
// - input pin pulls up when control low
// - analog pin loses digital input, pull-up
// - pins carry remapped peripheral in/out
// - large package drives host address pins
// - debug disables other functions on pins
// - debug logic sets data pin direction
// - reset analog default from configuration bit
// - input mismatches ORed set change flag
// - output pins excluded from change compare
// - port access ends mismatch; wait, clear
// - output pins never have pull-up
`include "upc_cfg.svh"

module upc_port_top #(
   parameter bit LARGE_PKG = 1'b1   // 0 for the small package without host address
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // configuration strap
   input  wire logic        analog_default_select_i,
   // pads of the upper nibble
   input  wire logic [3:0]  pin_i,
   output logic      [3:0]  pin_o,
   output logic      [3:0]  pin_oe_o,
   output logic      [3:0]  pullup_en_o,
   // remappable peripherals
   input  wire logic [3:0]  remap_sel_i,
   input  wire logic [3:0]  remap_out_i,
   output logic      [3:0]  remap_in_o,
   // parallel host port address
   input  wire logic        host_port_en_i,
   input  wire logic [1:0]  host_port_addr_i,
   // in-circuit debugger
   input  wire logic        in_circuit_debugger_en_i,
   input  wire logic        debug_data_oe_i,
   input  wire logic        debug_data_out_i,
   output logic             debug_serial_clock_o,
   output logic             debug_serial_data_o,
   // interrupts
   output logic             port_change_irq_o,
   output logic             port_change_priority_o,
   output logic             irq_o
);
   logic              req;        // new bus request this cycle
   logic              wr0;        // write with the low byte lane on
   logic              port_touch; // any access to the pin register
   logic [31:0]       rd_data;    // read mux
   logic              mismatch;   // change detector result
   upc_pkg::upc_nib_t lat_ff;     // output latch, upper nibble
   upc_pkg::upc_nib_t dir_ff;     // direction, 1 = input
   upc_pkg::upc_reg_t intc_ff;    // main interrupt control
   upc_pkg::upc_reg_t intc2_ff;   // pull-up and priority control
   upc_pkg::upc_reg_t intc3_ff;   // external interrupt control, stored only
   logic              an_ff;      // analog enable of the analog pin
   logic              stat_ff;    // sticky change event
   logic              mask_ff;    // event mask
   logic              ack_ff;     // bus acknowledge
   logic [31:0]       dat_ff;     // registered read data
   upc_pkg::upc_nib_t din;        // digital levels from the cells
   logic              nxt_flag;   // next change flag

   // one request per bus cycle; ack gap keeps it single
   assign req        = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr0        = req && wb_we_i && wb_sel_i[0];
   // a read or a write of the pin register refreshes the old copy
   assign port_touch = req && (wb_adr_i == `UPC_OFF_PINS);

   // read mux; lower nibble of port registers belongs elsewhere, reads zero
   always_comb begin
      case (wb_adr_i)
         `UPC_OFF_PINS:     rd_data = {24'h0, din, 4'h0};
         `UPC_OFF_LATCH:    rd_data = {24'h0, lat_ff, 4'h0};
         `UPC_OFF_DIR:      rd_data = {24'h0, dir_ff, 4'h0};
         `UPC_OFF_INTC:     rd_data = {24'h0, intc_ff};
         `UPC_OFF_INTC2:    rd_data = {24'h0, intc2_ff};
         `UPC_OFF_INTC3:    rd_data = {24'h0, intc3_ff};
         `UPC_OFF_ANSEL:    rd_data = {27'h0, an_ff, 4'h0};
         `UPC_OFF_IRQ_STAT: rd_data = {31'h0, stat_ff};
         `UPC_OFF_IRQ_MASK: rd_data = {31'h0, mask_ff};
         default:           rd_data = 32'h0;
      endcase
   end

   // bus handshake: ack one cycle after the request, for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else begin
         ack_ff <= req;
         if (req) begin
            // unmapped addresses still answer, with zero
            dat_ff <= wb_we_i ? 32'h0 : rd_data;
         end
      end
   end

   // output latch: pin and latch offsets both land here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_ff <= `UPC_RST_LATCH;
      end else if (wr0 && (wb_adr_i == `UPC_OFF_PINS || wb_adr_i == `UPC_OFF_LATCH)) begin
         lat_ff <= wb_dat_i[7:4];
      end
   end

   // direction register; all inputs out of reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_ff <= `UPC_RST_DIR;
      end else if (wr0 && wb_adr_i == `UPC_OFF_DIR) begin
         dir_ff <= wb_dat_i[7:4];
      end
   end

   // change flag: a live mismatch sets it again, so set beats clear
   always_comb begin
      nxt_flag = intc_ff[`UPC_INTC_FLAG_BIT];
      if (wr0 && wb_adr_i == `UPC_OFF_INTC) begin
         nxt_flag = wb_dat_i[`UPC_INTC_FLAG_BIT];
      end
      if (mismatch) begin
         nxt_flag = 1'b1;
      end
   end

   // main interrupt control, flag bit handled above
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         intc_ff <= `UPC_RST_INTC;
      end else begin
         if (wr0 && wb_adr_i == `UPC_OFF_INTC) begin
            intc_ff <= wb_dat_i[7:0];
         end
         intc_ff[`UPC_INTC_FLAG_BIT] <= nxt_flag;
      end
   end

   // pull-up control and priority; other bits only stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         intc2_ff <= `UPC_RST_INTC2;
         intc3_ff <= `UPC_RST_INTC3;
      end else if (wr0) begin
         if (wb_adr_i == `UPC_OFF_INTC2) begin
            intc2_ff <= wb_dat_i[7:0];
         end
         if (wb_adr_i == `UPC_OFF_INTC3) begin
            intc3_ff <= wb_dat_i[7:0];
         end
      end
   end

   // analog enable takes the strap while reset is held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         an_ff <= analog_default_select_i;
      end else if (wr0 && wb_adr_i == `UPC_OFF_ANSEL) begin
         an_ff <= wb_dat_i[`UPC_ANSEL_AN_BIT];
      end
   end

   // sticky event, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_ff <= 1'b0;
         mask_ff <= 1'b0;
      end else begin
         if (mismatch) begin
            stat_ff <= 1'b1;
         end else if (wr0 && wb_adr_i == `UPC_OFF_IRQ_STAT && wb_dat_i[0]) begin
            stat_ff <= 1'b0;
         end
         if (wr0 && wb_adr_i == `UPC_OFF_IRQ_MASK) begin
            mask_ff <= wb_dat_i[0];
         end
      end
   end

   // interrupt and debug outputs, each one cycle behind its source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o                  <= 1'b0;
         port_change_irq_o      <= 1'b0;
         port_change_priority_o <= 1'b0;
         debug_serial_clock_o   <= 1'b0;
         debug_serial_data_o    <= 1'b0;
      end else begin
         irq_o                  <= stat_ff && mask_ff;
         port_change_irq_o      <= intc_ff[`UPC_INTC_FLAG_BIT] && intc_ff[`UPC_INTC_IE_BIT];
         port_change_priority_o <= intc2_ff[`UPC_INTC2_PRIO_BIT];
         // debugger sees raw pad levels only while it is enabled
         debug_serial_clock_o   <= in_circuit_debugger_en_i && pin_i[`UPC_DBG_CLK_PIN];
         debug_serial_data_o    <= in_circuit_debugger_en_i && pin_i[`UPC_DBG_DAT_PIN];
      end
   end

   assign wb_ack_o   = ack_ff;
   assign wb_dat_o   = dat_ff;
   assign remap_in_o = din;

   // one cell per upper pin; roles fixed by position
   for (genvar i = 0; i < 4; i++) begin : g_pin
      upc_pin_cell #(
         .HAS_ANALOG (i == `UPC_AN_PIN),
         .HAS_HADDR  (LARGE_PKG && (i == `UPC_HADDR0_PIN || i == `UPC_HADDR1_PIN)),
         .DBG_ROLE   ((i == `UPC_DBG_CLK_PIN) ? `UPC_DBG_CLK :
                      (i == `UPC_DBG_DAT_PIN) ? `UPC_DBG_DAT : `UPC_DBG_NONE)
      ) u_cell (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .latch_i     (lat_ff[i]),
         .dir_i       (dir_ff[i]),
         .pud_n_i     (intc2_ff[`UPC_INTC2_PUD_BIT]),
         .analog_i    (an_ff),
         .remap_sel_i (remap_sel_i[i]),
         .remap_out_i (remap_out_i[i]),
         .haddr_en_i  (host_port_en_i),
         .haddr_i     (host_port_addr_i[(i == `UPC_HADDR1_PIN) ? 1 : 0]),
         .dbg_en_i    (in_circuit_debugger_en_i),
         .dbg_oe_i    (debug_data_oe_i),
         .dbg_out_i   (debug_data_out_i),
         .pin_i       (pin_i[i]),
         .pin_o       (pin_o[i]),
         .pin_oe_o    (pin_oe_o[i]),
         .pullup_o    (pullup_en_o[i]),
         .din_o       (din[i])
      );
   end

   // compares input levels with the copy from the last port access
   upc_change_det u_change (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .din_i      (din),
      .dir_i      (dir_ff),
      .snap_i     (port_touch),
      .mismatch_o (mismatch)
   );

   ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   latch_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !dir_ff[1] && !remap_sel_i[1] && !host_port_en_i && !in_circuit_debugger_en_i
      |=> pin_oe_o[1] && pin_o[1] == $past(lat_ff[1]))
      else $error("output pin not driven from latch");
   pullup_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dir_ff[3] && !intc2_ff[`UPC_INTC2_PUD_BIT] && !in_circuit_debugger_en_i
      |=> pullup_en_o[3]) else $error("input pull-up missing");
   host_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      LARGE_PKG && host_port_en_i && !dir_ff[1] && !in_circuit_debugger_en_i
      |=> pin_o[1] == $past(host_port_addr_i[0]))
      else $error("host address not on pin");
   debug_takes_a: assert property (@(posedge clk_i) disable iff (rst_i)
      in_circuit_debugger_en_i |=> !pin_oe_o[`UPC_DBG_CLK_PIN] && !din[`UPC_DBG_CLK_PIN]
      && !pullup_en_o[`UPC_DBG_CLK_PIN]) else $error("debug clock pin shared");
   debug_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
      in_circuit_debugger_en_i |=> pin_oe_o[`UPC_DBG_DAT_PIN] == $past(debug_data_oe_i))
      else $error("debug data direction wrong");
   strap_load_a: assert property (@(posedge clk_i)
      rst_i |=> an_ff == $past(analog_default_select_i))
      else $error("analog default not loaded");
   // the irq output is built from the enable one cycle earlier, hence the past value
   flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mismatch |=> intc_ff[`UPC_INTC_FLAG_BIT]
      ##1 (port_change_irq_o || !$past(intc_ff[`UPC_INTC_IE_BIT])))
      else $error("change flag not set");
   pin_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && wb_adr_i == `UPC_OFF_PINS |=> wb_ack_o && wb_dat_o[7:4] == $past(din))
      else $error("pin read wrong");
endmodule

/* verification/upc_pad_model.sv */
// external pads of the upper nibble: keypad switches and pull-ups
module upc_pad_model (
   // clock
   input  wire logic       clk_i,
   // what the port drives
   input  wire logic [3:0] dut_out_i,
   input  wire logic [3:0] dut_oe_i,
   input  wire logic [3:0] dut_pu_i,
   // outside drivers from the bench
   input  wire logic [3:0] ext_en_i,
   input  wire logic [3:0] ext_val_i,
   // resolved pad levels
   output logic      [3:0] pad_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] last_ff = 4'hf;  // last driven pad level; never driven floats low

   // a floating pad shows the inverse of its last driven level, so a held value never passes
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         if (dut_oe_i[k]) begin
            pad_o[k] = dut_out_i[k];
         end else if (ext_en_i[k]) begin
            pad_o[k] = ext_val_i[k];
         end else if (dut_pu_i[k]) begin
            pad_o[k] = 1'b1;
         end else begin
            pad_o[k] = ~last_ff[k];
         end
      end
   end

   // history for the floating case, kept only while something drives the pad
   // so a released pad stays put instead of toggling into false changes
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 4; k++) begin
         if (dut_oe_i[k] || ext_en_i[k] || dut_pu_i[k]) begin
            last_ff[k] <= pad_o[k];
         end
      end
   end
endmodule

/* verification/upper_port_pin_control_tb_top.sv */
`include "upc_cfg.svh"

module upper_port_pin_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i = 1'b0;
   logic        rst_i, cyc, stb, we, strap, hp_en, dbg_en, dbg_oe, dbg_out;
   logic [7:0]  adr;
   logic [3:0]  sel, pad, ext_en, ext_val, rsel, rout, v;
   logic [31:0] dat, rdat;
   logic        ack, pcirq, prio, irq, dclk, ddat;
   logic [3:0]  po, poe, pu, rin;
   logic [1:0]  hpa;
   logic [15:0] e;
   logic [15:0] exp_q[$];  // address and expected read byte
   int          fail_count = 0;
   int          check_count = 0;

   // 125 MHz
   always #4 clk_i = ~clk_i;

   upc_port_top i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .analog_default_select_i(strap), .pin_i(pad), .pin_o(po), .pin_oe_o(poe),
      .pullup_en_o(pu), .remap_sel_i(rsel), .remap_out_i(rout), .remap_in_o(rin),
      .host_port_en_i(hp_en), .host_port_addr_i(hpa),
      .in_circuit_debugger_en_i(dbg_en), .debug_data_oe_i(dbg_oe),
      .debug_data_out_i(dbg_out), .debug_serial_clock_o(dclk),
      .debug_serial_data_o(ddat), .port_change_irq_o(pcirq),
      .port_change_priority_o(prio), .irq_o(irq));

   upc_pad_model i_pads (
      .clk_i(clk_i), .dut_out_i(po), .dut_oe_i(poe), .dut_pu_i(pu),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         $display("mismatch ack exp 1 got 0");
         end_sim();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'h1);
   endtask

   // expected byte is queued, the watcher compares it
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back({a, x});
      wb(1'b0, a, 8'h00, 4'h1);
   endtask

   // let pad registers land; the values read here stood for several cycles
   task automatic settle();
      repeat (4) @(posedge clk_i);
   endtask

   task automatic pk(input string nm, input logic [3:0] x, input logic [3:0] g);
      check_count++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", nm, x, g);
      end
   endtask

   // read data watcher: oldest note against each read ack
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         check_count++;
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("mismatch rd exp none got %h", rdat);
         end else begin
            e = exp_q.pop_front();
            if (rdat !== {24'h0, e[7:0]}) begin
               fail_count++;
               $display("mismatch rd %h exp %h got %h", e[15:8], e[7:0], rdat);
            end
         end
      end
   end

   task automatic do_reset(input logic s);
      strap <= s;
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   initial begin
      {cyc, stb, we, hp_en, dbg_en, dbg_oe, dbg_out} <= '0;
      {adr, sel, dat, ext_en, ext_val, rsel, rout, hpa} <= '0;
      v = 4'($urandom(32'h768d9493));
      do_reset(1'b0);
      // reset image, strap low
      rd(`UPC_OFF_LATCH, 8'h00);
      rd(`UPC_OFF_DIR, 8'hf0);
      rd(`UPC_OFF_INTC, 8'h00);
      rd(`UPC_OFF_INTC2, 8'h80);
      rd(`UPC_OFF_INTC3, 8'h00);
      rd(`UPC_OFF_ANSEL, 8'h00);
      rd(`UPC_OFF_IRQ_STAT, 8'h00);
      rd(`UPC_OFF_IRQ_MASK, 8'h00);
      rd(8'h40, 8'h00);
      settle();
      pk("pu_rst", 4'h0, pu);
      // pull-ups: global enable, analog pin, output pins
      wr(`UPC_OFF_INTC2, 8'h00);
      settle();
      pk("pu_on", 4'hf, pu);
      wr(`UPC_OFF_ANSEL, 8'h10);
      settle();
      pk("pu_an", 4'he, pu);
      wr(`UPC_OFF_LATCH, 8'ha0);
      wr(`UPC_OFF_DIR, 8'h50);
      settle();
      pk("pu_out", 4'h4, pu);
      pk("oe_mix", 4'ha, poe);
      wr(`UPC_OFF_DIR, 8'h00);
      settle();
      pk("po_lat", 4'ha, po);
      wr(`UPC_OFF_PINS, 8'h50);
      settle();
      pk("po_pins", 4'h5, po);
      rd(`UPC_OFF_LATCH, 8'h50);
      // input levels, analog pin reads low
      ext_en <= 4'hf;
      ext_val <= 4'h7;
      wr(`UPC_OFF_DIR, 8'hf0);
      settle();
      rd(`UPC_OFF_PINS, 8'h60);
      pk("rin_an", 4'h6, rin);
      wr(`UPC_OFF_ANSEL, 8'h00);
      settle();
      rd(`UPC_OFF_PINS, 8'h70);
      // remapped inputs, random levels
      for (int i = 0; i < 4; i++) begin
         v = 4'($urandom);
         ext_val <= v;
         settle();
         pk("rin", v, rin);
      end
      // remapped outputs
      ext_en <= 4'h0;
      rsel <= 4'hf;
      wr(`UPC_OFF_DIR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 4'($urandom);
         rout <= v;
         settle();
         pk("rout", v, po);
      end
      // host address bits on two pins
      rsel <= 4'h0;
      hp_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         hpa <= 2'(i);
         settle();
         pk("haddr", {2'h0, hpa[0], hpa[1]}, {2'h0, po[1:0]});
      end
      hp_en <= 1'b0;
      // debugger owns clock and data pins
      dbg_en <= 1'b1;
      dbg_oe <= 1'b1;
      dbg_out <= 1'b1;
      ext_en <= 4'h4;
      ext_val <= 4'h4;
      settle();
      pk("dbg_oe", 4'h2, {2'h0, poe[3:2]});
      pk("dbg_po", 4'h1, {3'h0, po[3]});
      pk("dbg_clk", 4'h1, {3'h0, dclk});
      wr(`UPC_OFF_DIR, 8'hf0);
      dbg_oe <= 1'b0;
      ext_en <= 4'hc;
      ext_val <= 4'hc;
      settle();
      pk("dbg_dir", 4'h0, {3'h0, poe[3]});
      pk("dbg_dat", 4'h1, {3'h0, ddat});
      pk("dbg_rin", 4'h0, {2'h0, rin[3:2]});
      pk("dbg_pu", 4'h0, {2'h0, pu[3:2]});
      dbg_en <= 1'b0;
      // change detect, interrupt raise, mask, clear
      ext_en <= 4'hf;
      ext_val <= 4'h0;
      settle();
      rd(`UPC_OFF_PINS, 8'h00);
      wr(`UPC_OFF_INTC, 8'h08);
      wr(`UPC_OFF_IRQ_STAT, 8'h01);
      wr(`UPC_OFF_IRQ_MASK, 8'h01);
      settle();
      pk("irq_idle", 4'h0, {2'h0, pcirq, irq});
      ext_val <= 4'h2;
      settle();
      rd(`UPC_OFF_INTC, 8'h09);
      pk("irq_set", 4'h3, {2'h0, pcirq, irq});
      wr(`UPC_OFF_IRQ_MASK, 8'h00);
      settle();
      pk("irq_mask", 4'h0, {3'h0, irq});
      wr(`UPC_OFF_INTC, 8'h08);
      rd(`UPC_OFF_INTC, 8'h09);
      rd(`UPC_OFF_PINS, 8'h20);
      settle();
      wr(`UPC_OFF_INTC, 8'h08);
      rd(`UPC_OFF_INTC, 8'h08);
      wr(`UPC_OFF_IRQ_STAT, 8'h01);
      wr(`UPC_OFF_IRQ_MASK, 8'h01);
      settle();
      pk("irq_clr", 4'h0, {2'h0, pcirq, irq});
      // an output pin toggling stays out of the compare
      wr(`UPC_OFF_DIR, 8'he0);
      ext_en <= 4'he;
      wr(`UPC_OFF_LATCH, 8'h40);
      wr(`UPC_OFF_LATCH, 8'h50);
      settle();
      rd(`UPC_OFF_INTC, 8'h08);
      wr(`UPC_OFF_INTC2, 8'h01);
      settle();
      pk("prio", 4'h1, {3'h0, prio});
      // stored register, disabled lane, unmapped write
      wr(`UPC_OFF_INTC3, 8'h5a);
      rd(`UPC_OFF_INTC3, 8'h5a);
      wb(1'b1, `UPC_OFF_LATCH, 8'hff, 4'he);
      rd(`UPC_OFF_LATCH, 8'h50);
      wr(8'h40, 8'hff);
      rd(8'h40, 8'h00);
      // second reset with strap high: analog default
      do_reset(1'b1);
      rd(`UPC_OFF_ANSEL, 8'h10);
      rd(`UPC_OFF_LATCH, 8'h00);
      ext_val <= 4'hf;
      settle();
      pk("rin_por", 4'he, rin);
      end_sim();
   end
endmodule
